// ===== pmcc_cfg.svh
// Behaviour
// R1 - writing select code all-ones in FAST mode moves system clock to sub clock (SLOW)
// R2 - SLOW switch completes only once slow oscillator is stable; old clock kept meanwhile
// R3 - codes 000..110 from SLOW return to high-speed clock divided by 1..64
// R4 - return to FAST waits for fast oscillator restart, seen via stable flag
// R5 - halt with both idle enables low is the only way into SLEEP
// R6 - SLEEP stops all clocks except the watchdog on the slow oscillator
// R7 - halt with high enable 0, low enable 1 enters low-clock idle
// R8 - halt with both idle enables 1 enters dual-clock idle
// R9 - halt with high enable 1, low enable 0 enters high-clock idle
// R10 - power-down stops execution at halt and holds memory, registers, ports
// R11 - every halt entry sets power-down flag and clears timeout flag
// R12 - every halt entry clears watchdog counter, which then counts on
// R13 - wake on port A falling edge, system interrupt or watchdog overflow
// R14 - power-down flag cleared only by power-up or clear-watchdog
// R15 - watchdog wake sets timeout flag, resets only PC and stack pointer
// R16 - each port A pin has a wake enable; wake resumes after halt
// R17 - disabled interrupt or full stack: resume after halt, request stays pending
// R18 - enabled interrupt with free stack: normal interrupt response
// R19 - request already set before power-down is no wake source then
// R20 - after wake hold off operation until original oscillator is stable
// R21 - fast oscillator enable or frequency change clears then resets stable flag
// R22 - slow oscillator runs while watchdog is enabled even if low idle enable is 0
// R23 - CPU clock stays gated while down; all halt side effects in the accept cycle
`ifndef PMCC_CFG_SVH
`define PMCC_CFG_SVH
`define SEL_SUB      3'h7
`define SEL_RST      3'h0
`define ADDR_SCC     12'h000
`define ADDR_FOSC    12'h004
`define ADDR_STATUS  12'h008
`define ADDR_WAKE    12'h00C
`define FOSC_RST     3'h1
`define OSC_STABLE_NS 1000
`define NS_PER_CYC    50
`define OSC_CYC ((`OSC_STABLE_NS + `NS_PER_CYC - 1) / `NS_PER_CYC)
`endif

// ===== pmcc_pkg.sv
package pmcc_pkg;
	typedef enum logic [2:0] {
		MODE_FAST,
		MODE_SLOW,
		MODE_SLEEP,
		MODE_IDLE_LOW,
		MODE_IDLE_DUAL,
		MODE_IDLE_HIGH
	} mode_t;
endpackage

// ===== power_mode_clock_control.sv
`timescale 1ns/1ns
`default_nettype none
`include "pmcc_cfg.svh"
module power_mode_clock_control #(
	parameter int PINS    = 8,
	parameter int NIRQ    = 8,
	parameter int OSC_CYC = `OSC_CYC
) (
	// apb
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	// cpu core
	input  wire logic             halt_exec,
	input  wire logic             clr_wdt_exec,
	input  wire logic             stack_full,
	output logic                  cpu_clk_en,
	output logic                  pc_sp_reset,
	output logic                  irq_take,
	output logic [NIRQ-1:0]       irq_take_sel,
	// oscillators and watchdog
	input  wire logic             slow_osc_ready,
	input  wire logic             wdt_overflow,
	output logic                  fast_osc_run,
	output logic                  slow_osc_run,
	output logic                  sysclk_use_sub,
	output logic [2:0]            sysclk_div_sel,
	output logic                  high_speed_clock_en,
	output logic                  sub_clock_en,
	output logic                  wdt_clear,
	// wake sources
	input  wire logic [PINS-1:0]  porta_in,
	input  wire logic [NIRQ-1:0]  irq_req,
	input  wire logic [NIRQ-1:0]  irq_enable,
	// status
	output logic [2:0]            mode,
	output logic                  power_down_flag,
	output logic                  watchdog_timeout_flag
);
	pmcc_pkg::mode_t       mode_q;
	logic [2:0]            sysclk_select_q;
	logic                  high_osc_idle_enable_q;
	logic                  low_osc_idle_enable_q;
	logic                  fosc_en_q;
	logic [1:0]            fosc_freq_q;
	logic                  fast_osc_stable_flag_q;
	logic [15:0]           stab_cnt_q;
	logic [PINS-1:0]       porta_wake_enable_q;
	logic [PINS-1:0]       porta_prev_q;
	logic [NIRQ-1:0]       irq_masked_q;
	logic [NIRQ-1:0]       irq_wake_q;
	logic                  wake_hold_q;
	logic                  pd_q;
	logic                  to_q;
	logic                  wdt_clear_q;
	logic                  pcsp_q;
	logic                  take_q;
	logic [NIRQ-1:0]       take_sel_q;
	logic [31:0]           prdata_q;
	logic                  wr;
	logic                  rd;
	logic                  halt_ok;
	logic                  down;
	logic                  fosc_restart;
	logic [PINS-1:0]       pin_fall;
	logic [NIRQ-1:0]       new_irq;
	logic                  wake;

	function automatic logic [NIRQ-1:0] lowest(input logic [NIRQ-1:0] v);
		logic [NIRQ-1:0] r;
		r = '0;
		for (int i = NIRQ - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = '0;
				r[i] = 1'b1;
			end
		end
		return r;
	endfunction

	assign wr      = psel && penable && pwrite;
	assign rd      = psel && !penable && !pwrite;
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign prdata  = prdata_q;
	// halt is only accepted while running normally
	assign halt_ok = halt_exec && !down && !wake_hold_q;
	assign down    = (mode_q != pmcc_pkg::MODE_FAST) && (mode_q != pmcc_pkg::MODE_SLOW);
	assign fosc_restart = wr && (paddr == `ADDR_FOSC)
		&& ((pwdata[0] && !fosc_en_q) || (pwdata[0] && pwdata[3:2] != fosc_freq_q));
	assign pin_fall = porta_wake_enable_q & porta_prev_q & ~porta_in;
	assign new_irq  = irq_req & ~irq_masked_q;
	assign wake     = down && (|pin_fall || |new_irq || wdt_overflow); // see R13 see R16 see R19

	// software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sysclk_select_q        <= `SEL_RST;
			high_osc_idle_enable_q <= 1'b0;
			low_osc_idle_enable_q  <= 1'b0;
			fosc_en_q              <= 1'b1;
			fosc_freq_q            <= 2'h0;
			porta_wake_enable_q    <= '0;
		end else if (wr) begin
			case (paddr)
				`ADDR_SCC: begin
					sysclk_select_q        <= pwdata[7:5];
					high_osc_idle_enable_q <= pwdata[1];
					low_osc_idle_enable_q  <= pwdata[0];
				end
				`ADDR_FOSC: begin
					fosc_en_q   <= pwdata[0];
					fosc_freq_q <= pwdata[3:2];
				end
				`ADDR_WAKE: porta_wake_enable_q <= pwdata[PINS-1:0]; // see R16
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0;
		end else if (rd) begin
			case (paddr)
				`ADDR_SCC:    prdata_q <= {24'h0, sysclk_select_q, 3'h0,
					high_osc_idle_enable_q, low_osc_idle_enable_q};
				`ADDR_FOSC:   prdata_q <= {28'h0, fosc_freq_q, fast_osc_stable_flag_q,
					fosc_en_q}; // see R4
				`ADDR_STATUS: prdata_q <= {26'h0, wake_hold_q, to_q, pd_q, mode_q};
				`ADDR_WAKE:   prdata_q <= 32'(porta_wake_enable_q);
				default:      prdata_q <= 32'h0;
			endcase
		end
	end

	// fast oscillator stabilisation; the counter stands in for the analog settle time
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stab_cnt_q             <= 16'(OSC_CYC);
			fast_osc_stable_flag_q <= 1'b0;
		end else if (fosc_restart || !fast_osc_run) begin
			stab_cnt_q             <= 16'(OSC_CYC); // see R21 see R4
			fast_osc_stable_flag_q <= 1'b0;
		end else if (stab_cnt_q != 16'h0) begin
			stab_cnt_q <= stab_cnt_q - 16'h1;
		end else begin
			fast_osc_stable_flag_q <= 1'b1; // see R21
		end
	end

	// operating mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q      <= pmcc_pkg::MODE_FAST;
			wake_hold_q <= 1'b0;
		end else if (halt_ok) begin
			case ({high_osc_idle_enable_q, low_osc_idle_enable_q})
				2'b00:   mode_q <= pmcc_pkg::MODE_SLEEP;     // see R5 see R23
				2'b01:   mode_q <= pmcc_pkg::MODE_IDLE_LOW;  // see R7
				2'b11:   mode_q <= pmcc_pkg::MODE_IDLE_DUAL; // see R8
				default: mode_q <= pmcc_pkg::MODE_IDLE_HIGH; // see R9
			endcase
		end else if (wake) begin
			mode_q      <= (sysclk_select_q == `SEL_SUB) ? pmcc_pkg::MODE_SLOW
				: pmcc_pkg::MODE_FAST;
			wake_hold_q <= 1'b1; // see R20
		end else if (wake_hold_q) begin
			if (mode_q == pmcc_pkg::MODE_SLOW ? slow_osc_ready : fast_osc_stable_flag_q)
				wake_hold_q <= 1'b0; // see R20
		end else begin
			case (mode_q)
				pmcc_pkg::MODE_FAST:
					if (sysclk_select_q == `SEL_SUB && slow_osc_ready)
						mode_q <= pmcc_pkg::MODE_SLOW; // see R1 see R2
				pmcc_pkg::MODE_SLOW:
					if (sysclk_select_q != `SEL_SUB && fast_osc_stable_flag_q)
						mode_q <= pmcc_pkg::MODE_FAST; // see R3 see R4
				default: ;
			endcase
		end
	end

	// status flags: halt sets power-down, clear-watchdog clears it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pd_q <= 1'b0;
			to_q <= 1'b0;
		end else begin
			if (halt_ok)
				pd_q <= 1'b1; // see R11
			else if (clr_wdt_exec)
				pd_q <= 1'b0; // see R14
			if (halt_ok)
				to_q <= 1'b0; // see R11
			else if (down && wdt_overflow)
				to_q <= 1'b1; // see R15
		end
	end

	// wake sources, pulses toward the core
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			porta_prev_q <= '0;
			irq_masked_q <= '0;
			irq_wake_q   <= '0;
			wdt_clear_q  <= 1'b0;
			pcsp_q       <= 1'b0;
			take_q       <= 1'b0;
			take_sel_q   <= '0;
		end else begin
			porta_prev_q <= porta_in;
			if (halt_ok)
				irq_masked_q <= irq_req; // see R19
			wdt_clear_q  <= halt_ok || clr_wdt_exec; // see R12
			pcsp_q       <= wake && wdt_overflow; // see R15
			if (wake)
				irq_wake_q <= new_irq;
			// unserviceable requests simply stay in the controller
			take_q     <= wake && !wdt_overflow && |(new_irq & irq_enable) && !stack_full;
			take_sel_q <= lowest(new_irq & irq_enable); // see R17 see R18
		end
	end

	// clocks; cpu stays gated while down or waiting for stability
	assign cpu_clk_en          = !down && !wake_hold_q && !halt_ok; // see R10 see R23
	assign sysclk_use_sub      = (mode_q == pmcc_pkg::MODE_SLOW);
	assign sysclk_div_sel      = sysclk_select_q;
	// the select code alone must not keep it alive in sleep or low idle
	assign fast_osc_run        = fosc_en_q && (mode_q == pmcc_pkg::MODE_FAST
		|| mode_q == pmcc_pkg::MODE_IDLE_DUAL || mode_q == pmcc_pkg::MODE_IDLE_HIGH
		|| (mode_q == pmcc_pkg::MODE_SLOW && sysclk_select_q != `SEL_SUB)
		|| wake_hold_q); // see R6 see R7 see R4
	assign high_speed_clock_en = fast_osc_run && fast_osc_stable_flag_q; // see R6
	assign sub_clock_en        = !(mode_q == pmcc_pkg::MODE_SLEEP
		|| mode_q == pmcc_pkg::MODE_IDLE_HIGH); // see R6 see R9
	assign slow_osc_run        = 1'b1; // see R22 see R6
	assign wdt_clear           = wdt_clear_q;
	assign pc_sp_reset         = pcsp_q;
	assign irq_take            = take_q;
	assign irq_take_sel        = take_sel_q & {NIRQ{take_q}};
	assign mode                = mode_q;
	assign power_down_flag     = pd_q;
	assign watchdog_timeout_flag = to_q;
endmodule
`default_nettype wire

// ===== osc_model.sv
`timescale 1ns/1ns
`default_nettype none
module osc_model (
	// clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// slow oscillator
	input  wire logic slow_osc_run,
	output logic      slow_osc_ready
);
	logic [1:0] cnt_q;
	// settles a few cycles after start so the mode switch has to wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 2'h0;
			slow_osc_ready <= 1'b0;
		end else if (!slow_osc_run) begin
			cnt_q <= 2'h0;
			slow_osc_ready <= 1'b0;
		end else if (cnt_q != 2'h3) begin
			cnt_q <= cnt_q + 2'h1;
		end else begin
			slow_osc_ready <= 1'b1;
		end
	end
endmodule
`default_nettype wire

// ===== pmcc_props.sv
`timescale 1ns/1ns
`default_nettype none
module pmcc_props #(
	parameter int NIRQ = 8
) (
	input  wire logic            pclk,
	input  wire logic            presetn,
	input  wire logic            halt_exec,
	input  wire logic            clr_wdt_exec,
	input  wire logic            stack_full,
	input  wire logic            cpu_clk_en,
	input  wire logic            pc_sp_reset,
	input  wire logic            irq_take,
	input  wire logic [NIRQ-1:0] irq_take_sel,
	input  wire logic            slow_osc_run,
	input  wire logic            sysclk_use_sub,
	input  wire logic            high_speed_clock_en,
	input  wire logic            sub_clock_en,
	input  wire logic            wdt_clear,
	input  wire logic [2:0]      mode,
	input  wire logic            power_down_flag,
	input  wire logic            watchdog_timeout_flag
);
	logic down;
	assign down = !(mode == pmcc_pkg::MODE_FAST || mode == pmcc_pkg::MODE_SLOW);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_entry_flags: assert property ($past(!down) && down |-> power_down_flag &&
		!watchdog_timeout_flag && $past(halt_exec)) else $error("entry flags wrong");
	a_entry_wdt_clr: assert property ($past(!down) && down |-> ##[0:1] wdt_clear)
		else $error("no watchdog clear on entry");
	a_sleep_clocks: assert property (mode == pmcc_pkg::MODE_SLEEP |->
		!high_speed_clock_en && !sub_clock_en) else $error("clock on in sleep");
	a_idle_low: assert property (mode == pmcc_pkg::MODE_IDLE_LOW |->
		!high_speed_clock_en && sub_clock_en) else $error("low idle clocks wrong");
	a_idle_dual: assert property (mode == pmcc_pkg::MODE_IDLE_DUAL |->
		high_speed_clock_en && sub_clock_en) else $error("dual idle clocks wrong");
	a_idle_high: assert property (mode == pmcc_pkg::MODE_IDLE_HIGH |->
		high_speed_clock_en && !sub_clock_en) else $error("high idle clocks wrong");
	a_cpu_gated: assert property (down |-> !cpu_clk_en) else $error("cpu clock on");
	a_slow_runs: assert property (1'b1 |-> slow_osc_run) else $error("slow osc off");
	a_pd_clear: assert property ($fell(power_down_flag) |-> $past(clr_wdt_exec) &&
		!$past(halt_exec)) else $error("pd cleared without cause");
	a_wdt_wake: assert property (pc_sp_reset |-> watchdog_timeout_flag && !irq_take)
		else $error("watchdog wake flags wrong");
	a_irq_take: assert property (irq_take |-> $onehot(irq_take_sel) &&
		!$past(stack_full)) else $error("bad interrupt take");
	a_sub_select: assert property (!down |-> sysclk_use_sub == (mode ==
		pmcc_pkg::MODE_SLOW)) else $error("clock source wrong");
endmodule
bind power_mode_clock_control pmcc_props #(.NIRQ(NIRQ)) props (.*);
`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        halt_exec = 0, clr_wdt_exec = 0, stack_full = 0, wdt_overflow = 0;
	logic [7:0]  porta_in = 8'hFF, irq_req = 8'h00, irq_enable = 8'h00, irq_take_sel;
	logic        pready, cpu_clk_en, pc_sp_reset, irq_take, slow_osc_run, slow_osc_ready;
	logic [31:0] rq[$], eq[$];
	logic [2:0]  exp_m[4] = '{pmcc_pkg::MODE_SLEEP, pmcc_pkg::MODE_IDLE_LOW,
		pmcc_pkg::MODE_IDLE_HIGH, pmcc_pkg::MODE_IDLE_DUAL};
	int          n_errors = 0, compares = 0;
	integer      seed = 32'h01D50A32;
	power_mode_clock_control #(.PINS(8), .NIRQ(8), .OSC_CYC(2)) dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(), .halt_exec(halt_exec),
		.clr_wdt_exec(clr_wdt_exec), .stack_full(stack_full), .cpu_clk_en(cpu_clk_en),
		.pc_sp_reset(pc_sp_reset), .irq_take(irq_take), .irq_take_sel(irq_take_sel),
		.slow_osc_ready(slow_osc_ready), .wdt_overflow(wdt_overflow), .fast_osc_run(),
		.slow_osc_run(slow_osc_run), .sysclk_use_sub(), .sysclk_div_sel(),
		.high_speed_clock_en(), .sub_clock_en(), .wdt_clear(), .porta_in(porta_in),
		.irq_req(irq_req), .irq_enable(irq_enable), .mode(), .power_down_flag(),
		.watchdog_timeout_flag());
	osc_model osc (.pclk(pclk), .presetn(presetn), .slow_osc_run(slow_osc_run),
		.slow_osc_ready(slow_osc_ready));
	initial begin
		forever #25 pclk = ~pclk;
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task print_verdict;
		if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		if (!w) rq.push_back(d);
		@(posedge pclk) penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task halt_go;
		@(posedge pclk) halt_exec <= 1'b1;
		@(posedge pclk) halt_exec <= 1'b0;
	endtask
	task wait_up;
		int i;
		i = 0;
		@(posedge pclk); #1;
		while (cpu_clk_en !== 1'b1 && i < 100) begin
			@(posedge pclk); #1; i++;
		end
	endtask
	function logic [31:0] st(input logic t, input logic p, input logic [2:0] m);
		return {27'h0, t, p, m};
	endfunction
	// results are compared in order of issue, each against the oldest queued expectation
	always @(posedge pclk) begin
		if (presetn && psel && penable && pready && !pwrite) chk("prdata", rq.pop_front(), prdata);
		if (irq_take === 1'b1 || pc_sp_reset === 1'b1) chk("wake event",
			eq.size() ? eq.pop_front() : 32'hFFFFFFFF,
			{22'h0, pc_sp_reset, irq_take, irq_take_sel & {8{irq_take}}});
	end
	initial begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		print_verdict;
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		apb(0, 12'h000, 32'h0); apb(0, 12'h004, 32'h3); apb(0, 12'h010, 32'h0);
		apb(1, 12'h014, 32'hFF); apb(1, 12'h00C, 32'h1); apb(0, 12'h000, 32'h0);
		for (int k = 0; k < 4; k++) begin
			apb(1, 12'h000, k);
			halt_go;
			repeat (4) @(posedge pclk) porta_in <= 8'($random(seed)) | 8'h01;
			apb(0, 12'h008, st(0, 1, exp_m[k]));
			@(posedge pclk) porta_in <= 8'hFE;
			wait_up;
			porta_in <= 8'hFF;
			apb(0, 12'h008, st(0, 1, pmcc_pkg::MODE_FAST));
		end
		irq_enable <= 8'h04; irq_req <= 8'h08;
		halt_go;
		repeat (4) @(posedge pclk);
		apb(0, 12'h008, st(0, 1, pmcc_pkg::MODE_IDLE_DUAL));
		eq.push_back(32'h104);
		@(posedge pclk) irq_req <= 8'h0C;
		wait_up;
		halt_go;
		@(posedge pclk) irq_req <= 8'h1C;
		wait_up;
		apb(0, 12'h008, st(0, 1, pmcc_pkg::MODE_FAST));
		irq_req <= 8'h00;
		@(posedge pclk) clr_wdt_exec <= 1'b1;
		@(posedge pclk) clr_wdt_exec <= 1'b0;
		apb(0, 12'h008, st(0, 0, pmcc_pkg::MODE_FAST));
		apb(1, 12'h000, 32'hE0);
		repeat (10) @(posedge pclk);
		apb(0, 12'h008, st(0, 0, pmcc_pkg::MODE_SLOW));
		apb(1, 12'h000, 32'h60);
		repeat (20) @(posedge pclk);
		apb(0, 12'h008, st(0, 0, pmcc_pkg::MODE_FAST)); apb(0, 12'h000, 32'h60);
		halt_go;
		eq.push_back(32'h200);
		@(posedge pclk) wdt_overflow <= 1'b1;
		@(posedge pclk) wdt_overflow <= 1'b0;
		wait_up;
		apb(0, 12'h008, st(1, 1, pmcc_pkg::MODE_FAST));
		apb(1, 12'h004, 32'h5); apb(0, 12'h004, 32'h5);
		repeat (10) @(posedge pclk);
		apb(0, 12'h004, 32'h7);
		repeat (4) @(posedge pclk);
		print_verdict;
	end
endmodule
`default_nettype wire
